// *** src/iam_regs.vh ***
// Register offsets, field positions and encodings of the IPv4 entry match block
`ifndef IAM_REGS_VH
`define IAM_REGS_VH

// Register offsets (word index on the plain port)
`define IAM_REG_CTRL 4'h0
`define IAM_REG_PROTO 4'h1
`define IAM_REG_SRC_ADDR 4'h2
`define IAM_REG_SRC_MASK 4'h3
`define IAM_REG_DST_ADDR 4'h4
`define IAM_REG_DST_MASK 4'h5
`define IAM_REG_STATUS 4'h6
`define IAM_REG_HIT_COUNT 4'h7

// Control register fields
`define IAM_CTRL_FTYPE_LSB 0
`define IAM_CTRL_PROTO_LSB 2
`define IAM_CTRL_TTL_LSB 5
`define IAM_CTRL_FRAG_LSB 7
`define IAM_CTRL_OPT_LSB 9
`define IAM_CTRL_SRC_LSB 11
`define IAM_CTRL_DST_LSB 13
`define IAM_CTRL_OTHER_LSB 15
`define IAM_CTRL_RESET 32'h00000000

// Frame type selection
`define IAM_FTYPE_ANY 2'h0
`define IAM_FTYPE_IPV4 2'h1

// Protocol criterion
`define IAM_PROTO_ANY 3'h0
`define IAM_PROTO_SPECIFIC 3'h1
`define IAM_PROTO_ICMP 3'h2
`define IAM_PROTO_UDP 3'h3
`define IAM_PROTO_TCP 3'h4

// Standard protocol numbers
`define IAM_NUM_ICMP 8'h01
`define IAM_NUM_UDP 8'h11
`define IAM_NUM_TCP 8'h06

// Tri-state criteria: time-to-live, fragment, options
`define IAM_TRI_ANY 2'h0
`define IAM_TRI_NO 2'h1
`define IAM_TRI_YES 2'h2

// Address criterion
`define IAM_ADDR_ANY 2'h0
`define IAM_ADDR_HOST 2'h1
`define IAM_ADDR_NET 2'h2

`endif

// *** src/iam_addr_match.v ***
// Address comparison for one entry: any, host or masked network
`timescale 1ns/100ps
`default_nettype none
`include "iam_regs.vh"

module iam_addr_match (
  // Criterion
  input wire [1:0] mode,
  input wire [31:0] cfg_addr,
  input wire [31:0] cfg_mask,
  // Frame
  input wire [31:0] frame_addr,
  // Result
  output reg pass
);

  always @* begin
    case (mode)
      `IAM_ADDR_ANY: pass = 1'b1;
      `IAM_ADDR_HOST: pass = (frame_addr == cfg_addr);
      `IAM_ADDR_NET: pass = ((frame_addr & cfg_mask) == (cfg_addr & cfg_mask));
      default: pass = 1'b0;
    endcase
  end

endmodule // iam_addr_match
`default_nettype wire

// *** src/iam_tri_match.v ***
// Three-way flag criterion: any, no or yes
`timescale 1ns/100ps
`default_nettype none
`include "iam_regs.vh"

module iam_tri_match (
  // Criterion and frame flag
  input wire [1:0] mode,
  input wire flag,
  // Result
  output reg pass
);

  always @* begin
    case (mode)
      `IAM_TRI_ANY: pass = 1'b1;
      `IAM_TRI_NO: pass = ~flag;
      `IAM_TRI_YES: pass = flag;
      default: pass = 1'b0;
    endcase
  end

endmodule // iam_tri_match
`default_nettype wire

// *** src/iam_ipv4_match.v ***
// IPv4 match logic for one access control entry of the switch
//
// Summary of operation
// - IPv4 criteria apply only for IPv4 frame type
// - Protocol any ignores the protocol field
// - Specific protocol must equal configured value
// - ICMP/UDP/TCP select protocol, enable sub-criteria
// - TTL zero excludes frames with TTL above zero
// - TTL non-zero admits TTL above zero; any ignores
// - Fragment no excludes MF or nonzero offset frames
// - Fragment yes admits fragments; any ignores state
// - Options no excludes frames carrying header options
// - Options yes admits optioned frames; any ignores
// - Source any disregards the source address
// - Source host needs exact source address
// - Source network compares only masked bits
// - Destination any disregards destination address
// - Destination host needs exact destination address
// - Destination network compares where mask is one
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "iam_regs.vh"

module iam_ipv4_match (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Parsed frame header from ingress
  input wire frame_valid,
  input wire frame_is_ipv4,
  input wire [7:0] frame_protocol,
  input wire [7:0] frame_ttl,
  input wire frame_more_fragments,
  input wire [12:0] frame_fragment_offset,
  input wire frame_has_options,
  input wire [31:0] frame_source_ipv4_address,
  input wire [31:0] frame_destination_ipv4_address,
  // Result of the entry's other criteria, same cycle as frame_valid
  input wire other_criteria_pass,
  // Match result
  output reg result_valid,
  output reg entry_hit,
  output reg icmp_sub_enable,
  output reg udp_sub_enable,
  output reg tcp_sub_enable
);

  // Configuration
  reg [1:0] frame_type_sel;
  reg [2:0] proto_sel;
  reg [1:0] ttl_sel;
  reg [1:0] frag_sel;
  reg [1:0] opt_sel;
  reg [1:0] src_sel;
  reg [1:0] dst_sel;
  reg other_enable;
  reg [7:0] proto_value;
  reg [31:0] source_ipv4_address;
  reg [31:0] source_address_mask;
  reg [31:0] destination_ipv4_address;
  reg [31:0] destination_address_mask;

  // Status
  reg last_hit;
  reg [15:0] hit_count;

  wire [31:0] ctrl_word;
  wire ttl_pass;
  wire frag_pass;
  wire opt_pass;
  wire src_pass;
  wire dst_pass;
  reg proto_pass;
  wire ipv4_pass;
  wire next_hit;

  // True when the entry selects IPv4 frames and the given named protocol
  function sub_sel;
    input [1:0] ftype;
    input [2:0] psel;
    input [2:0] named;
    begin
      sub_sel = (ftype == `IAM_FTYPE_IPV4) && (psel == named);
    end
  endfunction

  // Any fragment state: more-fragments set or a nonzero offset
  function is_fragment;
    input mf;
    input [12:0] offset;
    begin
      is_fragment = mf | (offset != 13'h0);
    end
  endfunction

  // Protocol criterion; ICMP/UDP/TCP use the standard assigned numbers
  always @* begin
    case (proto_sel)
      `IAM_PROTO_ANY: proto_pass = 1'b1;
      `IAM_PROTO_SPECIFIC: proto_pass = (frame_protocol == proto_value);
      `IAM_PROTO_ICMP: proto_pass = (frame_protocol == `IAM_NUM_ICMP);
      `IAM_PROTO_UDP: proto_pass = (frame_protocol == `IAM_NUM_UDP);
      `IAM_PROTO_TCP: proto_pass = (frame_protocol == `IAM_NUM_TCP);
      default: proto_pass = 1'b0;
    endcase
  end

  // Zero selects frames whose TTL is zero, non-zero those above it
  iam_tri_match u_ttl (
    .mode(ttl_sel),
    .flag(frame_ttl != 8'h00),
    .pass(ttl_pass)
  );

  iam_tri_match u_frag (
    .mode(frag_sel),
    .flag(is_fragment(frame_more_fragments, frame_fragment_offset)),
    .pass(frag_pass)
  );

  iam_tri_match u_opt (
    .mode(opt_sel),
    .flag(frame_has_options),
    .pass(opt_pass)
  );

  iam_addr_match u_src (
    .mode(src_sel),
    .cfg_addr(source_ipv4_address),
    .cfg_mask(source_address_mask),
    .frame_addr(frame_source_ipv4_address),
    .pass(src_pass)
  );

  iam_addr_match u_dst (
    .mode(dst_sel),
    .cfg_addr(destination_ipv4_address),
    .cfg_mask(destination_address_mask),
    .frame_addr(frame_destination_ipv4_address),
    .pass(dst_pass)
  );

  // IPv4 criteria only count when the entry selects IPv4 frames
  assign ipv4_pass = (frame_type_sel != `IAM_FTYPE_IPV4) ||
                     (frame_is_ipv4 & proto_pass & ttl_pass & frag_pass &
                      opt_pass & src_pass & dst_pass);

  // Other criteria are gated in only when software enables them
  assign next_hit = ipv4_pass & (~other_enable | other_criteria_pass);

  assign ctrl_word = {16'h0000, other_enable, dst_sel, src_sel, opt_sel, frag_sel,
                      ttl_sel, proto_sel, frame_type_sel};

  // Registered result, one cycle after the frame strobe
  always @(posedge ref_clk) begin
    if (rst) begin
      result_valid <= 1'b0;
      entry_hit <= 1'b0;
      icmp_sub_enable <= 1'b0;
      udp_sub_enable <= 1'b0;
      tcp_sub_enable <= 1'b0;
      last_hit <= 1'b0;
      hit_count <= 16'h0000;
    end else begin
      result_valid <= frame_valid;
      entry_hit <= frame_valid & next_hit;
      // Sub-criteria follow only an IPv4 entry with a named protocol
      icmp_sub_enable <= sub_sel(frame_type_sel, proto_sel, `IAM_PROTO_ICMP);
      udp_sub_enable <= sub_sel(frame_type_sel, proto_sel, `IAM_PROTO_UDP);
      tcp_sub_enable <= sub_sel(frame_type_sel, proto_sel, `IAM_PROTO_TCP);
      if (frame_valid) begin
        last_hit <= next_hit;
      end
      // Counter saturates so software never sees a wrap as few hits
      if (reg_wr && reg_addr == `IAM_REG_HIT_COUNT) begin
        if (frame_valid && next_hit) begin
          hit_count <= 16'h0001;
        end else begin
          hit_count <= 16'h0000;
        end
      end else if (frame_valid && next_hit && hit_count != 16'hFFFF) begin
        hit_count <= hit_count + 16'h0001;
      end
    end
  end

  // Register writes
  always @(posedge ref_clk) begin
    if (rst) begin
      frame_type_sel <= `IAM_FTYPE_ANY;
      proto_sel <= `IAM_PROTO_ANY;
      ttl_sel <= `IAM_TRI_ANY;
      frag_sel <= `IAM_TRI_ANY;
      opt_sel <= `IAM_TRI_ANY;
      src_sel <= `IAM_ADDR_ANY;
      dst_sel <= `IAM_ADDR_ANY;
      other_enable <= 1'b0;
      proto_value <= 8'h00;
      source_ipv4_address <= 32'h00000000;
      source_address_mask <= 32'h00000000;
      destination_ipv4_address <= 32'h00000000;
      destination_address_mask <= 32'h00000000;
    end else if (reg_wr) begin
      case (reg_addr)
        `IAM_REG_CTRL: begin
          frame_type_sel <= reg_wdata[`IAM_CTRL_FTYPE_LSB +: 2];
          proto_sel <= reg_wdata[`IAM_CTRL_PROTO_LSB +: 3];
          ttl_sel <= reg_wdata[`IAM_CTRL_TTL_LSB +: 2];
          frag_sel <= reg_wdata[`IAM_CTRL_FRAG_LSB +: 2];
          opt_sel <= reg_wdata[`IAM_CTRL_OPT_LSB +: 2];
          src_sel <= reg_wdata[`IAM_CTRL_SRC_LSB +: 2];
          dst_sel <= reg_wdata[`IAM_CTRL_DST_LSB +: 2];
          other_enable <= reg_wdata[`IAM_CTRL_OTHER_LSB];
        end
        `IAM_REG_PROTO: proto_value <= reg_wdata[7:0];
        `IAM_REG_SRC_ADDR: source_ipv4_address <= reg_wdata;
        `IAM_REG_SRC_MASK: source_address_mask <= reg_wdata;
        `IAM_REG_DST_ADDR: destination_ipv4_address <= reg_wdata;
        `IAM_REG_DST_MASK: destination_address_mask <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Register reads: data stand in the cycle after the strobe only
  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `IAM_REG_CTRL: begin
          reg_rdata <= ctrl_word;
        end
        `IAM_REG_PROTO: begin
          reg_rdata <= {24'h000000, proto_value};
        end
        `IAM_REG_SRC_ADDR: begin
          reg_rdata <= source_ipv4_address;
        end
        `IAM_REG_SRC_MASK: begin
          reg_rdata <= source_address_mask;
        end
        `IAM_REG_DST_ADDR: begin
          reg_rdata <= destination_ipv4_address;
        end
        `IAM_REG_DST_MASK: begin
          reg_rdata <= destination_address_mask;
        end
        `IAM_REG_STATUS: begin
          reg_rdata <= {31'h0, last_hit};
        end
        `IAM_REG_HIT_COUNT: begin
          reg_rdata <= {16'h0000, hit_count};
        end
        default: begin
          reg_rdata <= 32'h00000000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // iam_ipv4_match
`default_nettype wire

// *** sim/iam_props.sv ***
// Checker bound to the IPv4 entry match block
`timescale 1ns/100ps
`default_nettype none
`include "iam_regs.vh"
module iam_props (
  // Clock, reset, register writes
  input wire logic ref_clk, rst, reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  // Frame header and result
  input wire logic frame_valid, frame_is_ipv4, frame_more_fragments, frame_has_options,
  input wire logic [7:0] frame_protocol, frame_ttl,
  input wire logic [12:0] frame_fragment_offset,
  input wire logic result_valid, entry_hit, icmp_sub_enable, udp_sub_enable, tcp_sub_enable
);
  // Control shadow; a frame on the write edge still sees the old word
  logic [15:0] c;
  logic v4, fv;
  logic [2:0] pr, sub;
  always_ff @(posedge ref_clk) begin
    if (rst) c <= 16'h0000;
    else if (reg_wr && reg_addr == `IAM_REG_CTRL) c <= reg_wdata[15:0];
  end
  assign v4 = c[1:0] == `IAM_FTYPE_IPV4;
  assign fv = frame_valid && v4 && frame_is_ipv4;
  assign pr = c[4:2];
  assign sub = {3{v4}} & {pr == 3'h2, pr == 3'h3, pr == 3'h4};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    !reg_wr [*2];
  endsequence
  sequence s_miss;
    result_valid && !entry_hit;
  endsequence
  AST_LAT: assert property (frame_valid |=> result_valid)
    else $error("No result");
  AST_IDLE: assert property (!frame_valid |=> !result_valid && !entry_hit)
    else $error("Result without frame");
  AST_TYPE: assert property (frame_valid && v4 && !frame_is_ipv4 |=> s_miss)
    else $error("Non-IPv4 hit");
  AST_TCP: assert property (fv && pr == `IAM_PROTO_TCP &&
    frame_protocol != `IAM_NUM_TCP |=> s_miss) else $error("Wrong protocol hit");
  AST_TTL: assert property (fv && c[6:5] == `IAM_TRI_NO && frame_ttl != 8'h00
    |=> s_miss) else $error("TTL hit");
  AST_FRAG: assert property (fv && c[8:7] == `IAM_TRI_NO &&
    (frame_more_fragments || frame_fragment_offset != 13'h0000) |=> s_miss)
    else $error("Fragment hit");
  AST_OPT: assert property (fv && c[10:9] == `IAM_TRI_NO && frame_has_options
    |=> s_miss) else $error("Options hit");
  AST_SUB: assert property (s_quiet |->
    {icmp_sub_enable, udp_sub_enable, tcp_sub_enable} == sub) else $error("Sub enable");
endmodule // iam_props
bind iam_ipv4_match iam_props iam_props_inst (.*);
`default_nettype wire

// *** sim/iam_ingress_model.sv ***
// Ingress parser stand-in: one parsed header per call
`timescale 1ns/100ps
`default_nettype none
module iam_ingress_model (
  // Clock
  input wire logic ref_clk,
  // Parsed header toward the entry
  output logic frame_valid, frame_is_ipv4, frame_more_fragments, frame_has_options,
  output logic other_criteria_pass,
  output logic [7:0] frame_protocol, frame_ttl,
  output logic [12:0] frame_fragment_offset,
  output logic [31:0] frame_source_ipv4_address, frame_destination_ipv4_address
);
  logic [96:0] hdr = '0;
  assign {frame_is_ipv4, frame_protocol, frame_ttl, frame_more_fragments,
    frame_fragment_offset, frame_has_options, frame_source_ipv4_address,
    frame_destination_ipv4_address, other_criteria_pass} = hdr;
  initial frame_valid = 1'b0;
  // Off the strobe the fields turn inverse, so a stale sample cannot pass
  task send(input logic [96:0] h);
    @(posedge ref_clk);
    {frame_valid, hdr} <= {1'b1, h};
    @(posedge ref_clk);
    {frame_valid, hdr} <= {1'b0, ~h};
  endtask
endmodule // iam_ingress_model
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the IPv4 entry match block
`timescale 1ns/100ps
`default_nettype none
`include "iam_regs.vh"
module tb_top;
  logic ref_clk = 1'b0;
  logic rst, reg_wr, reg_rd, frame_valid, frame_is_ipv4, frame_more_fragments;
  logic frame_has_options, other_criteria_pass, result_valid, entry_hit;
  logic icmp_sub_enable, udp_sub_enable, tcp_sub_enable, v4, mf, opt, oth;
  logic [3:0] reg_addr;
  logic [7:0] frame_protocol, frame_ttl, p, t;
  logic [12:0] frame_fragment_offset, off;
  logic [31:0] reg_wdata, reg_rdata, sa, da;
  logic [31:0] frame_source_ipv4_address, frame_destination_ipv4_address;
  logic [7:0] num [3] = '{8'h01, 8'h11, 8'h06};
  int lsb [4] = '{5, 7, 7, 9};
  int error_cnt = 0;
  int tests_run = 0;
  iam_ipv4_match iam_ipv4_match_inst (.*);
  iam_ingress_model iam_ingress_model_inst (.*);
  initial forever #2 ref_clk = ~ref_clk;
  task end_sim;
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read data stand for one cycle only, so they are checked there
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge ref_clk);
    {reg_wr, reg_rd} <= 2'b00;
    if (!w) begin
      #1 chk(reg_rdata, d);
      @(posedge ref_clk);
      #1 chk(reg_rdata, 32'h0);
    end
  endtask
  task cfx(input int l, input int m);
    bus(1'b1, `IAM_REG_CTRL, 32'h1 | m << l);
  endtask
  task dflt;
    {v4, mf, opt, oth, p, t, off} = {4'b1001, 8'h06, 8'h40, 13'h0000};
    {sa, da} = {32'h0A000001, 32'hC0A80001};
  endtask
  task go(input logic e);
    iam_ingress_model_inst.send({v4, p, t, mf, off, opt, sa, da, oth});
    #1 chk({result_valid, entry_hit}, {1'b1, e});
  endtask
  task s_type;
    bus(1'b0, `IAM_REG_CTRL, `IAM_CTRL_RESET);
    bus(1'b1, 4'hA, 32'hFFFFFFFF);
    bus(1'b0, 4'hA, 32'h0);
    dflt;
    cfx(`IAM_CTRL_TTL_LSB, `IAM_TRI_NO);
    v4 = 1'b0;
    go(1'b0);
    bus(1'b1, `IAM_REG_CTRL, 32'h20);
    go(1'b1);
    bus(1'b0, `IAM_REG_STATUS, 32'h1);
    bus(1'b1, `IAM_REG_HIT_COUNT, 32'h0);
    bus(1'b1, `IAM_REG_CTRL, 32'h8001);
    {v4, oth} = 2'b10;
    go(1'b0);
    oth = 1'b1;
    go(1'b1);
    bus(1'b0, `IAM_REG_HIT_COUNT, 32'h1);
  endtask
  task s_proto;
    dflt;
    p = 8'hFF;
    cfx(`IAM_CTRL_PROTO_LSB, `IAM_PROTO_ANY);
    go(1'b1);
    bus(1'b1, `IAM_REG_PROTO, 32'hFFFFFFFF);
    bus(1'b0, `IAM_REG_PROTO, 32'hFF);
    cfx(`IAM_CTRL_PROTO_LSB, `IAM_PROTO_SPECIFIC);
    go(1'b1);
    p = 8'hFE;
    go(1'b0);
    for (int i = 0; i < 3; i++) begin
      cfx(`IAM_CTRL_PROTO_LSB, `IAM_PROTO_ICMP + i);
      @(posedge ref_clk);
      #1 chk({icmp_sub_enable, udp_sub_enable, tcp_sub_enable}, 3'b100 >> i);
      p = num[i];
      go(1'b1);
      p = num[(i + 1) % 3];
      go(1'b0);
    end
  endtask
  // Each flag criterion in each mode, flag clear and at its smallest set value
  task s_tri;
    for (int k = 0; k < 4; k++)
      for (int m = 0; m < 3; m++)
        for (int f = 0; f < 2; f++) begin
          dflt;
          cfx(lsb[k], m);
          {t, mf, off, opt} = {7'h00, k == 0 && f, k == 1 && f, 12'h000, k == 2 && f, k == 3 && f};
          go(m == 0 || (m == 1) != f);
        end
  endtask
  task s_addr;
    for (int d = 0; d < 2; d++) begin
      dflt;
      bus(1'b1, `IAM_REG_SRC_ADDR + 2 * d, 32'hC0A80A05);
      bus(1'b1, `IAM_REG_SRC_MASK + 2 * d, 32'hFFFFFF00);
      bus(1'b0, `IAM_REG_SRC_MASK + 2 * d, 32'hFFFFFF00);
      for (int m = 0; m < 3; m++) begin
        cfx(d ? `IAM_CTRL_DST_LSB : `IAM_CTRL_SRC_LSB, m);
        {sa, da} = {2{32'hC0A80A05}};
        go(1'b1);
        {sa, da} = {2{32'hC0A80AFA}};
        go(m != 1);
        {sa, da} = {2{32'hC0A80B05}};
        go(m == 0);
      end
    end
  endtask
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 36'h0};
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    s_type;
    s_proto;
    s_tri;
    s_addr;
    end_sim;
  end
  // Run needs well under 1000 cycles
  initial begin
    #20000;
    error_cnt++;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
